// ### hw/analog_trigger_pkg.sv
package analog_trigger_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   // fine variant digitizes to 12 bits (4,096 steps); coarse uses the top 8 (256 steps)
   localparam int LEVEL_W = 12;
   localparam int COARSE_W = 8;
   localparam int COARSE_STEPS = 256;
   localparam int FINE_STEPS = 4096;
   // direct source step sizes in microvolts across the +/-10 V span
   localparam int DIRECT_STEP_COARSE_UV = 78000;
   localparam int DIRECT_STEP_FINE_UV = 4900;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [LEVEL_W-1:0] THRESHOLD_RESET = 12'h0000;
   localparam logic TRIGGER_RESET = 1'b0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_BELOW_LOW,
      MODE_ABOVE_HIGH,
      MODE_INSIDE_REGION,
      MODE_HIGH_HYSTERESIS,
      MODE_LOW_HYSTERESIS
   } trigger_mode_t;

   typedef enum logic {
      SOURCE_DIRECT,
      SOURCE_AMPLIFIER
   } trigger_source_t;

   localparam trigger_mode_t MODE_RESET = MODE_BELOW_LOW;
   localparam trigger_source_t SOURCE_RESET = SOURCE_DIRECT;

   // the two software-written threshold levels travel together
   typedef struct packed {
      logic [LEVEL_W-1:0] lower_threshold;
      logic [LEVEL_W-1:0] upper_threshold;
   } thresholds_t;

endpackage : analog_trigger_pkg

// ### hw/analog_level_trigger_logic.sv
// Functional notes
// - compare either direct input or amplifier output
// - direct source: 78 mV or 4.9 mV steps
// - amplifier source: full scale in 256/4096 steps
// - five modes, independent lower and upper thresholds
// - below-low: trigger while value below lower
// - above-high: trigger while value above upper
// - inside-region: trigger while between both thresholds
// - high-hysteresis: trigger on exceeding upper threshold
// - low-hysteresis: trigger on falling below lower
// - trigger output feeds all timing sections
`timescale 1ns/100ps
module analog_level_trigger_logic
   import analog_trigger_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic FINE_VARIANT,
   input wire trigger_source_t SOURCE_SELECT,
   input wire trigger_mode_t MODE_SELECT,
   input wire logic LOWER_WRITE,
   input wire logic [LEVEL_W-1:0] LOWER_THRESHOLD_IN,
   input wire logic UPPER_WRITE,
   input wire logic [LEVEL_W-1:0] UPPER_THRESHOLD_IN,
   input wire logic [LEVEL_W-1:0] DIRECT_TRIGGER_INPUT,
   input wire logic [LEVEL_W-1:0] PROGRAMMABLE_GAIN_AMPLIFIER,
   output logic [LEVEL_W-1:0] LOWER_THRESHOLD,
   output logic [LEVEL_W-1:0] UPPER_THRESHOLD,
   output logic ACQUISITION_TRIGGER,
   output logic UPDATE_TRIGGER,
   output logic COUNTER_TRIGGER
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // coarse variant keeps only the top bits so both variants share one compare
   function automatic logic [LEVEL_W-1:0] quantize(input logic [LEVEL_W-1:0] v,
                                                   input logic fine);
      quantize = fine ? v : {v[LEVEL_W-1 -: COARSE_W], {(LEVEL_W-COARSE_W){1'b0}}};
   endfunction : quantize

   // strict compare: a value sitting exactly on a level never counts as past it
   function automatic logic is_below(input logic [LEVEL_W-1:0] v,
                                     input logic [LEVEL_W-1:0] level);
      is_below = v < level;
   endfunction : is_below

   // mirror of is_below, kept separate so each mode reads like its rule
   function automatic logic is_above(input logic [LEVEL_W-1:0] v,
                                     input logic [LEVEL_W-1:0] level);
      is_above = v > level;
   endfunction : is_above

   // ---------------------------------------------------------------
   // thresholds
   // ---------------------------------------------------------------
   thresholds_t thr_reg;
   logic [LEVEL_W-1:0] value_reg;
   logic trig_reg;
   logic [LEVEL_W-1:0] value_next;
   logic trig_next;
   logic [LEVEL_W-1:0] source_value;
   // crossing flags shared by the modes; inside_window serves inside-region alone
   logic below_lower;
   logic above_upper;
   logic inside_window;

   // each threshold written on its own strobe, untouched by the other
   // a write lands at the strobe edge; the readback port follows one edge later
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         thr_reg.lower_threshold <= THRESHOLD_RESET;
         thr_reg.upper_threshold <= THRESHOLD_RESET;
      end else begin
         if (LOWER_WRITE) begin
            thr_reg.lower_threshold <= quantize(LOWER_THRESHOLD_IN, FINE_VARIANT);
         end
         if (UPPER_WRITE) begin
            thr_reg.upper_threshold <= quantize(UPPER_THRESHOLD_IN, FINE_VARIANT);
         end
      end
   end

   // ---------------------------------------------------------------
   // source select
   // ---------------------------------------------------------------
   // both sources arrive already digitized on CLK, so no synchroniser is needed;
   // the step size in volts (78 mV / 4.9 mV, or full scale / 256 / 4096) comes from
   // the digitizer's scaling, the logic only sees codes
   // source is a level; switching it mid-run simply changes what is compared
   always_comb begin
      source_value = (SOURCE_SELECT == SOURCE_AMPLIFIER) ? PROGRAMMABLE_GAIN_AMPLIFIER
                                                         : DIRECT_TRIGGER_INPUT;
   end

   // coarse compare drops the low bits of the value the same way as the levels,
   // so a value and a level that differ only below the coarse step compare equal
   always_comb begin
      value_next = quantize(source_value, FINE_VARIANT);
   end

   // compared value, refreshed on every edge
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         value_reg <= THRESHOLD_RESET;
      end else begin
         value_reg <= value_next;
      end
   end

   // ---------------------------------------------------------------
   // threshold crossings
   // ---------------------------------------------------------------
   // each crossing is worked out once and shared by the modes that need it;
   // with lower above upper the window is empty and hysteresis favours setting,
   // so software should keep lower at or below upper
   always_comb begin
      below_lower = is_below(value_reg, thr_reg.lower_threshold);
      above_upper = is_above(value_reg, thr_reg.upper_threshold);
      inside_window = is_above(value_reg, thr_reg.lower_threshold) &&
                      is_below(value_reg, thr_reg.upper_threshold);
   end

   // ---------------------------------------------------------------
   // comparison
   // ---------------------------------------------------------------
   // hysteresis state is the trigger itself, so one flop serves both
   // latency: a code is taken into value_reg at one edge and shows on the
   // trigger outputs at the next, two edges in all
   always_comb begin
      trig_next = trig_reg;
      unique case (MODE_SELECT)
         MODE_BELOW_LOW: begin
            trig_next = below_lower;
         end
         MODE_ABOVE_HIGH: begin
            trig_next = above_upper;
         end
         MODE_INSIDE_REGION: begin
            trig_next = inside_window;
         end
         MODE_HIGH_HYSTERESIS: begin
            if (above_upper) begin
               trig_next = 1'b1;
            end else if (below_lower) begin
               trig_next = 1'b0;
            end
         end
         MODE_LOW_HYSTERESIS: begin
            if (below_lower) begin
               trig_next = 1'b1;
            end else if (above_upper) begin
               trig_next = 1'b0;
            end
         end
         default: begin
            trig_next = TRIGGER_RESET; // illegal mode code holds trigger off
         end
      endcase
   end

   // hysteresis state; the hold branches above read it back
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         trig_reg <= TRIGGER_RESET;
      end else begin
         trig_reg <= trig_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // one flop per consumer keeps fan-out local to each timing section; all three
   // take trig_next so they change on the same edge as the hysteresis state,
   // which costs three flops but keeps the copies identical
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ACQUISITION_TRIGGER <= TRIGGER_RESET;
      end else begin
         ACQUISITION_TRIGGER <= trig_next;
      end
   end

   // output-update section copy
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         UPDATE_TRIGGER <= TRIGGER_RESET;
      end else begin
         UPDATE_TRIGGER <= trig_next;
      end
   end

   // counter section copy
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         COUNTER_TRIGGER <= TRIGGER_RESET;
      end else begin
         COUNTER_TRIGGER <= trig_next;
      end
   end

   // lower threshold readback, one edge behind the stored level
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LOWER_THRESHOLD <= THRESHOLD_RESET;
      end else begin
         LOWER_THRESHOLD <= thr_reg.lower_threshold;
      end
   end

   // upper threshold readback
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         UPPER_THRESHOLD <= THRESHOLD_RESET;
      end else begin
         UPPER_THRESHOLD <= thr_reg.upper_threshold;
      end
   end

endmodule : analog_level_trigger_logic

// ### test/timing_sections_model.sv
`timescale 1ns/100ps
// ----------------------------------------------
// acquisition, update and counter sections
// ----------------------------------------------
module timing_sections_model (
   input logic clk,
   input logic rst_n,
   input logic [2:0] trig,
   output int rises
);
   logic [2:0] last;
   // a section starts on a rising trigger; a rise seen on only some copies is not counted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last <= 3'h0;
         rises <= 0;
      end else begin
         last <= trig;
         rises <= rises + int'(trig == 3'h7 && last == 3'h0);
      end
   end
endmodule : timing_sections_model

// ### test/analog_level_trigger_logic_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------------
// trigger checker
// ----------------------------------------------
module trigger_rule_checker
   import analog_trigger_pkg::*;
(
   input logic CLK,
   input logic RESET_N,
   input logic FINE_VARIANT,
   input trigger_source_t SOURCE_SELECT,
   input trigger_mode_t MODE_SELECT,
   input logic [LEVEL_W-1:0] DIRECT_TRIGGER_INPUT,
   input logic [LEVEL_W-1:0] PROGRAMMABLE_GAIN_AMPLIFIER,
   input logic [LEVEL_W-1:0] LOWER_THRESHOLD,
   input logic [LEVEL_W-1:0] UPPER_THRESHOLD,
   input logic ACQUISITION_TRIGGER,
   input logic UPDATE_TRIGGER,
   input logic COUNTER_TRIGGER
);
   // compared value; coarse drops the low nibble
   wire [11:0] v = (SOURCE_SELECT == SOURCE_AMPLIFIER ? PROGRAMMABLE_GAIN_AMPLIFIER
      : DIRECT_TRIGGER_INPUT) & {8'hFF, {4{FINE_VARIANT}}};
   wire [11:0] lo = LOWER_THRESHOLD;
   wire [11:0] hi = UPPER_THRESHOLD;
   wire t = ACQUISITION_TRIGGER;
   logic [1:0] age;
   logic fp;
   // history across reset or a resolution change is not trusted
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) age <= 2'h0;
      else if (fp != FINE_VARIANT) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end
   always_ff @(posedge CLK) fp <= FINE_VARIANT;
   wire ok = age == 2'h3;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   property p_same; t == UPDATE_TRIGGER && t == COUNTER_TRIGGER; endproperty
   a_same: assert property (p_same) else $error("trigger copies differ");
   property p_below; ok && $past(MODE_SELECT) == MODE_BELOW_LOW |-> t == ($past(v, 2) < lo);
   endproperty
   a_below: assert property (p_below) else $error("below-low wrong");
   property p_above; ok && $past(MODE_SELECT) == MODE_ABOVE_HIGH |-> t == ($past(v, 2) > hi);
   endproperty
   a_above: assert property (p_above) else $error("above-high wrong");
   property p_inside; ok && $past(MODE_SELECT) == MODE_INSIDE_REGION
      |-> t == ($past(v, 2) > lo && $past(v, 2) < hi); endproperty
   a_inside: assert property (p_inside) else $error("inside wrong");
   property p_hset; ok && $past(MODE_SELECT) == MODE_HIGH_HYSTERESIS && $past(v, 2) > hi |-> t;
   endproperty
   a_hset: assert property (p_hset) else $error("high hysteresis not set");
   property p_hclr; ok && $past(MODE_SELECT) == MODE_HIGH_HYSTERESIS && $past(v, 2) < lo |-> !t;
   endproperty
   a_hclr: assert property (p_hclr) else $error("high hysteresis not cleared");
   property p_lset; ok && $past(MODE_SELECT) == MODE_LOW_HYSTERESIS && $past(v, 2) < lo |-> t;
   endproperty
   a_lset: assert property (p_lset) else $error("low hysteresis not set");
   property p_lclr; ok && $past(MODE_SELECT) == MODE_LOW_HYSTERESIS && $past(v, 2) > hi |-> !t;
   endproperty
   a_lclr: assert property (p_lclr) else $error("low hysteresis not cleared");
   property p_hhold; ok && $past(MODE_SELECT) == MODE_HIGH_HYSTERESIS && !($past(v, 2) > hi)
      && !($past(v, 2) < lo) |-> t == $past(t); endproperty
   a_hhold: assert property (p_hhold) else $error("high hysteresis did not hold");
   property p_lhold; ok && $past(MODE_SELECT) == MODE_LOW_HYSTERESIS && !($past(v, 2) > hi)
      && !($past(v, 2) < lo) |-> t == $past(t); endproperty
   a_lhold: assert property (p_lhold) else $error("low hysteresis did not hold");
endmodule : trigger_rule_checker
bind analog_level_trigger_logic trigger_rule_checker trigger_rule_checker_i (
   .CLK(CLK),
   .RESET_N(RESET_N),
   .FINE_VARIANT(FINE_VARIANT),
   .SOURCE_SELECT(SOURCE_SELECT),
   .MODE_SELECT(MODE_SELECT),
   .DIRECT_TRIGGER_INPUT(DIRECT_TRIGGER_INPUT),
   .PROGRAMMABLE_GAIN_AMPLIFIER(PROGRAMMABLE_GAIN_AMPLIFIER),
   .LOWER_THRESHOLD(LOWER_THRESHOLD),
   .UPPER_THRESHOLD(UPPER_THRESHOLD),
   .ACQUISITION_TRIGGER(ACQUISITION_TRIGGER),
   .UPDATE_TRIGGER(UPDATE_TRIGGER),
   .COUNTER_TRIGGER(COUNTER_TRIGGER)
);

// ### test/analog_level_trigger_logic_test.sv
`timescale 1ns/100ps
module analog_level_trigger_logic_test import analog_trigger_pkg::*;;
   localparam logic [11:0] VALS [6] = '{12'h200, 12'h400, 12'hE00, 12'h800, 12'h200, 12'h800};
   localparam logic [5:0] EXP [5] = '{6'h22, 6'h08, 6'h05, 6'h0C, 6'h33};
   logic clk = 1'h0, rst_n = 1'h0, fine = 1'h1, lw = 1'h0, uw = 1'h0, acq, upd, cnt;
   trigger_source_t src = SOURCE_DIRECT;
   trigger_mode_t mode = MODE_BELOW_LOW;
   logic [11:0] lin = 12'h000, uin = 12'h000, dv = 12'h000, av = 12'h000, lo, hi;
   int n_errors = 0, tests_run = 0, rises, r0;
   initial forever #2 clk = ~clk;
   analog_level_trigger_logic analog_level_trigger_logic_i (.CLK(clk), .RESET_N(rst_n),
      .FINE_VARIANT(fine), .SOURCE_SELECT(src), .MODE_SELECT(mode), .LOWER_WRITE(lw),
      .LOWER_THRESHOLD_IN(lin), .UPPER_WRITE(uw), .UPPER_THRESHOLD_IN(uin),
      .DIRECT_TRIGGER_INPUT(dv), .PROGRAMMABLE_GAIN_AMPLIFIER(av), .LOWER_THRESHOLD(lo),
      .UPPER_THRESHOLD(hi), .ACQUISITION_TRIGGER(acq), .UPDATE_TRIGGER(upd),
      .COUNTER_TRIGGER(cnt));
   timing_sections_model timing_sections_model_i (.clk(clk), .rst_n(rst_n),
      .trig({acq, upd, cnt}), .rises(rises));
   task chk(input string what, input logic [11:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task end_of_test;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // the unselected source carries the mirror value, so a wrong pick shows
   task drive(input logic [11:0] x);
      @(negedge clk);
      dv = src == SOURCE_AMPLIFIER ? ~x : x;
      av = src == SOURCE_AMPLIFIER ? x : ~x;
      repeat (3) @(negedge clk);
   endtask : drive
   // ----------------------------------------------
   // scenarios
   // ----------------------------------------------
   task t_reset;
      rst_n = 1'h0;
      repeat (12) @(negedge clk);
      chk("reset trigger", 12'h000, {9'h000, acq, upd, cnt});
      chk("reset lower", 12'h000, lo);
      rst_n = 1'h1;
   endtask : t_reset
   // both thresholds in one cycle; coarse keeps only the top byte
   task t_write(input logic [11:0] l, u);
      @(negedge clk);
      lin = l;
      uin = u;
      lw = 1'h1;
      uw = 1'h1;
      @(negedge clk);
      lw = 1'h0;
      uw = 1'h0;
      repeat (3) @(negedge clk);
      chk("lower", l & {8'hFF, {4{fine}}}, lo);
      chk("upper", u & {8'hFF, {4{fine}}}, hi);
   endtask : t_write
   task t_modes;
      for (int m = 0; m < 5; m++) begin
         mode = trigger_mode_t'(m);
         src = trigger_source_t'(m % 2);
         for (int i = 0; i < 6; i++) begin
            drive(VALS[i]);
            chk("trigger", {11'h000, EXP[m][5-i]}, {11'h000, acq});
         end
      end
   endtask : t_modes
   // 0x405 ties the truncated lower level, so no trigger when coarse
   task t_coarse;
      fine = 1'h0;
      t_write(12'h40F, 12'hC00);
      mode = MODE_BELOW_LOW;
      drive(12'h405);
      chk("coarse", 12'h000, {11'h000, acq});
      r0 = rises;
      drive(12'h3F0);
      chk("rises", 12'h001, 12'(rises - r0));
   endtask : t_coarse
   // an undefined mode code keeps the trigger off although below-low would fire
   task t_illegal;
      mode = trigger_mode_t'(3'h5);
      drive(12'h100);
      chk("illegal mode", 12'h000, {11'h000, acq});
   endtask : t_illegal
   initial begin
      t_reset;
      t_write(12'h400, 12'hC00);
      t_modes;
      t_coarse;
      t_illegal;
      t_reset;
      end_of_test;
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      end_of_test;
   end
endmodule : analog_level_trigger_logic_test
